// ---- logic/tcu_pkg.sv ----
// constants of the 16-bit timer, capture path and tick select.
// assumes one system clock and a byte-wide processor port.
// What this block does
// [RULE1] low write loads temp as high byte
// [RULE2] high locations hit temp; low read fills temp
// [RULE3] temp keeps high byte until rewritten
// [RULE4] three-bit tick select; zero stops
// [RULE5] counter accessible with or without ticks
// [RULE6] processor write beats clear or count
// [RULE7] mode field drives clear, count, top, bottom
// [RULE8] overflow flag set per mode
// [RULE9] selected edge copies counter to capture
// [RULE10] capture flag set with copy, gated interrupt
// [RULE11] flag clears on service or written one
// [RULE12] capture low read first fills temp
// [RULE13] capture writable only in capture-top modes
// [RULE14] comparator select switches trigger source
// [RULE15] software clears flag after source change
// [RULE16] triggers share tick pin conditioning
// [RULE17] filter changes after four equal samples
// [RULE18] filter adds four clock cycles
// [RULE19] filter enable bit, system clock
// [RULE20] trigger path idle in capture-top modes
// [RULE21] port output drive can trigger capture
// [RULE22] new capture overwrites unread value
// [RULE23] duty measurement: flip edge, clear flag
// [RULE24] one temp register shared by all
// [RULE25] bottom is zero, maximum is all ones
// [RULE26] one bit picks rising or falling edge
// [RULE27] reset clears all state, no source
package tcu_pkg;
    localparam int          COUNT_W      = 16;
    localparam int          FILTER_LEN   = 4;
    localparam int          PRESCALE_W   = 10;
    // byte locations on the processor port
    localparam logic [1:0]  LOC_COUNT_LO = 2'h0;
    localparam logic [1:0]  LOC_COUNT_HI = 2'h1;
    localparam logic [1:0]  LOC_CAP_LO   = 2'h2;
    localparam logic [1:0]  LOC_CAP_HI   = 2'h3;
    // counter limits and fixed tops
    localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
    localparam logic [15:0] COUNT_MAX    = 16'hffff;
    localparam logic [15:0] TOP_8BIT     = 16'h00ff;
    localparam logic [15:0] TOP_9BIT     = 16'h01ff;
    localparam logic [15:0] TOP_10BIT    = 16'h03ff;
    localparam logic [15:0] COUNT_ONE    = 16'h0001;
    localparam logic [7:0]  BYTE_ZERO    = 8'h00;
    // tick source codes
    localparam logic [2:0]  TICK_NONE    = 3'h0;
    localparam logic [2:0]  TICK_DIV1    = 3'h1;
    localparam logic [2:0]  TICK_DIV8    = 3'h2;
    localparam logic [2:0]  TICK_DIV64   = 3'h3;
    localparam logic [2:0]  TICK_DIV256  = 3'h4;
    localparam logic [2:0]  TICK_DIV1024 = 3'h5;
    localparam logic [2:0]  TICK_EXT_FALL = 3'h6;
    localparam logic [2:0]  TICK_EXT_RISE = 3'h7;
    localparam logic [9:0]  MASK_DIV8    = 10'h007;
    localparam logic [9:0]  MASK_DIV64   = 10'h03f;
    localparam logic [9:0]  MASK_DIV256  = 10'h0ff;
    localparam logic [9:0]  MASK_DIV1024 = 10'h3ff;
    localparam logic [9:0]  PRESCALE_ONE = 10'h001;
    // how the top value of a mode is chosen
    typedef enum logic [2:0] {
        TCU_TOP_MAX, TCU_TOP_8, TCU_TOP_9, TCU_TOP_10, TCU_TOP_CMP, TCU_TOP_CAP
    } tcu_top_kind_t;
    // how a mode walks its sequence
    typedef enum logic [1:0] {
        TCU_SEQ_NORMAL, TCU_SEQ_CTC, TCU_SEQ_FAST, TCU_SEQ_DUAL
    } tcu_seq_kind_t;
endpackage

// ---- logic/tcu_input_cond.sv ----
// synchroniser, optional four-sample filter and edge detector for one pin.
// assumes an asynchronous input; edges are one-cycle pulses.
`timescale 1ns/1ps
module tcu_input_cond (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic reset,
    // pin and option
    input  wire logic pin_in,
    input  wire logic filter_on,
    // edges
    output logic      rise,
    output logic      fall
);
    typedef struct packed {
        logic                            sync1;
        logic                            sync2;
        logic [tcu_pkg::FILTER_LEN-1:0]  hist;
        logic                            filt;
        logic                            last;
    } tcu_cond_state_t;

    tcu_cond_state_t state_reg;
    tcu_cond_state_t state_next;
    logic            filt_now;
    logic            level;

    always_comb begin
        state_next       = state_reg;
        state_next.sync1 = pin_in;
        state_next.sync2 = state_reg.sync1;
        // [RULE17] four equal samples
        state_next.hist  = {state_reg.hist[tcu_pkg::FILTER_LEN-2:0], state_reg.sync2};
        filt_now         = state_reg.filt;
        if (&state_reg.hist) begin
            filt_now = 1'b1;
        end else if (~|state_reg.hist) begin
            filt_now = 1'b0;
        end
        state_next.filt  = filt_now;
        // [RULE18] filter adds four cycles
        level            = filter_on ? filt_now : state_reg.sync2;
        state_next.last  = level;
        rise             = level & ~state_reg.last;
        fall             = ~level & state_reg.last;
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end
endmodule

// ---- logic/tcu_tick_select.sv ----
// prescaler and tick source selection.
// assumes external edges arrive as synchronised one-cycle pulses.
`timescale 1ns/1ps
module tcu_tick_select #(
    parameter int PRESCALE_W = tcu_pkg::PRESCALE_W
) (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       reset,
    // selection and external edges
    input  wire logic [2:0] tick_source_sel,
    input  wire logic       ext_rise,
    input  wire logic       ext_fall,
    // tick
    output logic            timer_tick
);
    typedef struct packed {
        logic [PRESCALE_W-1:0] pre;
        logic                  tick;
    } tcu_tick_state_t;

    tcu_tick_state_t state_reg;
    tcu_tick_state_t state_next;

    assign timer_tick = state_reg.tick;

    always_comb begin
        state_next     = state_reg;
        state_next.pre = state_reg.pre + PRESCALE_W'(tcu_pkg::PRESCALE_ONE);
        // [RULE4] zero source stops the counter
        case (tick_source_sel)
            tcu_pkg::TICK_NONE:     state_next.tick = 1'b0;
            tcu_pkg::TICK_DIV1:     state_next.tick = 1'b1;
            tcu_pkg::TICK_DIV8:     state_next.tick = &(state_reg.pre | ~tcu_pkg::MASK_DIV8);
            tcu_pkg::TICK_DIV64:    state_next.tick = &(state_reg.pre | ~tcu_pkg::MASK_DIV64);
            tcu_pkg::TICK_DIV256:   state_next.tick = &(state_reg.pre | ~tcu_pkg::MASK_DIV256);
            tcu_pkg::TICK_DIV1024:  state_next.tick = &(state_reg.pre | ~tcu_pkg::MASK_DIV1024);
            tcu_pkg::TICK_EXT_FALL: state_next.tick = ext_fall;
            tcu_pkg::TICK_EXT_RISE: state_next.tick = ext_rise;
            default:                state_next.tick = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end
endmodule

// ---- logic/tcu_timer16.sv ----
// 16-bit timer core: counter, capture, shared temp, flags.
// assumes a byte port with one-cycle strobes.
`timescale 1ns/1ps
module tcu_timer16 (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset,
    // processor byte port
    input  wire logic        bus_wr,
    input  wire logic        bus_rd,
    input  wire logic [1:0]  bus_addr,
    input  wire logic [7:0]  bus_wdata,
    output logic      [7:0]  bus_rdata,
    // configuration
    input  wire logic [3:0]  wave_mode_sel,
    input  wire logic [2:0]  tick_source_sel,
    input  wire logic        filter_enable,
    input  wire logic        edge_rising,
    input  wire logic        comparator_trigger_sel,
    input  wire logic        capture_irq_en,
    input  wire logic        overflow_irq_en,
    input  wire logic [15:0] compare_value_a,
    // flag clearing
    input  wire logic        capture_flag_wr1,
    input  wire logic        capture_irq_ack,
    input  wire logic        overflow_flag_wr1,
    input  wire logic        overflow_irq_ack,
    // pins
    input  wire logic        capture_pin,
    input  wire logic        capture_port_out,
    input  wire logic        capture_port_dir,
    input  wire logic        comparator_out,
    input  wire logic        ext_tick_pin,
    // status
    output logic [15:0]      count_value,
    output logic             count_top,
    output logic             count_bottom,
    output logic             capture_flag,
    output logic             overflow_flag,
    output logic             capture_irq,
    output logic             overflow_irq
);
    typedef struct packed {
        logic [15:0] count;
        logic [15:0] capture;
        logic [7:0]  temp;
        logic [7:0]  rdata;
        logic        down;
        logic        cap_flag;
        logic        ovf_flag;
        logic        cap_irq;
        logic        ovf_irq;
        logic        top;
        logic        bottom;
    } tcu_main_state_t;

    tcu_main_state_t         state_reg;
    tcu_main_state_t         state_next;
    tcu_pkg::tcu_top_kind_t  top_kind;
    tcu_pkg::tcu_seq_kind_t  seq_kind;
    logic [15:0]             top_value;
    logic                    cap_top_mode;
    logic                    timer_tick;
    logic                    ext_rise;
    logic                    ext_fall;
    logic                    trig_rise;
    logic                    trig_fall;
    logic                    trig_level;
    logic                    capture_event;
    logic                    at_top;
    logic                    ovf_event;
    logic                    wr_count_lo;
    logic                    wr_cap_lo;
    logic                    wr_hi;
    logic                    rd_count_lo;
    logic                    rd_cap_lo;

    assign bus_rdata     = state_reg.rdata;
    assign count_value   = state_reg.count;
    assign count_top     = state_reg.top;
    assign count_bottom  = state_reg.bottom;
    assign capture_flag  = state_reg.cap_flag;
    assign overflow_flag = state_reg.ovf_flag;
    assign capture_irq   = state_reg.cap_irq;
    assign overflow_irq  = state_reg.ovf_irq;

    // [RULE16] tick pin shares the conditioner
    tcu_input_cond u_ext_cond (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .pin_in    (ext_tick_pin),
        .filter_on (1'b0),
        .rise      (ext_rise),
        .fall      (ext_fall)
    );

    tcu_tick_select u_tick (
        .sys_clk         (sys_clk),
        .reset           (reset),
        .tick_source_sel (tick_source_sel),
        .ext_rise        (ext_rise),
        .ext_fall        (ext_fall),
        .timer_tick      (timer_tick)
    );

    // [RULE14] [RULE21] comparator, driven port or pin
    always_comb begin
        trig_level = capture_port_dir ? capture_port_out : capture_pin;
        if (comparator_trigger_sel) begin
            trig_level = comparator_out;
        end
    end

    // [RULE16] [RULE19] same conditioner, system-clock filter
    tcu_input_cond u_cap_cond (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .pin_in    (trig_level),
        .filter_on (filter_enable),
        .rise      (trig_rise),
        .fall      (trig_fall)
    );

    // [RULE7] mode field decides top and sequence
    always_comb begin
        case (wave_mode_sel)
            4'h1: begin
                top_kind = tcu_pkg::TCU_TOP_8;
                seq_kind = tcu_pkg::TCU_SEQ_DUAL;
            end
            4'h2: begin
                top_kind = tcu_pkg::TCU_TOP_9;
                seq_kind = tcu_pkg::TCU_SEQ_DUAL;
            end
            4'h3: begin
                top_kind = tcu_pkg::TCU_TOP_10;
                seq_kind = tcu_pkg::TCU_SEQ_DUAL;
            end
            4'h4: begin
                top_kind = tcu_pkg::TCU_TOP_CMP;
                seq_kind = tcu_pkg::TCU_SEQ_CTC;
            end
            4'h5: begin
                top_kind = tcu_pkg::TCU_TOP_8;
                seq_kind = tcu_pkg::TCU_SEQ_FAST;
            end
            4'h6: begin
                top_kind = tcu_pkg::TCU_TOP_9;
                seq_kind = tcu_pkg::TCU_SEQ_FAST;
            end
            4'h7: begin
                top_kind = tcu_pkg::TCU_TOP_10;
                seq_kind = tcu_pkg::TCU_SEQ_FAST;
            end
            4'h8, 4'ha: begin
                top_kind = tcu_pkg::TCU_TOP_CAP;
                seq_kind = tcu_pkg::TCU_SEQ_DUAL;
            end
            4'h9, 4'hb: begin
                top_kind = tcu_pkg::TCU_TOP_CMP;
                seq_kind = tcu_pkg::TCU_SEQ_DUAL;
            end
            4'hc: begin
                top_kind = tcu_pkg::TCU_TOP_CAP;
                seq_kind = tcu_pkg::TCU_SEQ_CTC;
            end
            4'he: begin
                top_kind = tcu_pkg::TCU_TOP_CAP;
                seq_kind = tcu_pkg::TCU_SEQ_FAST;
            end
            4'hf: begin
                top_kind = tcu_pkg::TCU_TOP_CMP;
                seq_kind = tcu_pkg::TCU_SEQ_FAST;
            end
            // mode 0 and the reserved code count freely
            default: begin
                top_kind = tcu_pkg::TCU_TOP_MAX;
                seq_kind = tcu_pkg::TCU_SEQ_NORMAL;
            end
        endcase
    end

    always_comb begin
        case (top_kind)
            tcu_pkg::TCU_TOP_8:   top_value = tcu_pkg::TOP_8BIT;
            tcu_pkg::TCU_TOP_9:   top_value = tcu_pkg::TOP_9BIT;
            tcu_pkg::TCU_TOP_10:  top_value = tcu_pkg::TOP_10BIT;
            tcu_pkg::TCU_TOP_CMP: top_value = compare_value_a;
            tcu_pkg::TCU_TOP_CAP: top_value = state_reg.capture;
            default:              top_value = tcu_pkg::COUNT_MAX;
        endcase
        cap_top_mode = (top_kind == tcu_pkg::TCU_TOP_CAP);
    end

    // [RULE2] [RULE24] byte decode; one shared temp
    always_comb begin
        wr_count_lo = bus_wr && (bus_addr == tcu_pkg::LOC_COUNT_LO);
        wr_cap_lo   = bus_wr && (bus_addr == tcu_pkg::LOC_CAP_LO);
        wr_hi       = bus_wr && ((bus_addr == tcu_pkg::LOC_COUNT_HI) ||
                                 (bus_addr == tcu_pkg::LOC_CAP_HI));
        rd_count_lo = bus_rd && !bus_wr && (bus_addr == tcu_pkg::LOC_COUNT_LO);
        rd_cap_lo   = bus_rd && !bus_wr && (bus_addr == tcu_pkg::LOC_CAP_LO);
    end

    // [RULE9] [RULE20] [RULE26] chosen edge, idle in capture-top modes
    assign capture_event = !cap_top_mode && (edge_rising ? trig_rise : trig_fall);

    always_comb begin
        state_next = state_reg;
        at_top     = (state_reg.count >= top_value);
        ovf_event  = 1'b0;

        // [RULE7] count on each tick
        if (timer_tick) begin
            case (seq_kind)
                tcu_pkg::TCU_SEQ_DUAL: begin
                    if (!state_reg.down) begin
                        if (at_top) begin
                            state_next.down  = 1'b1;
                            state_next.count = state_reg.count - tcu_pkg::COUNT_ONE;
                        end else begin
                            state_next.count = state_reg.count + tcu_pkg::COUNT_ONE;
                        end
                    end else if (state_reg.count == tcu_pkg::COUNT_BOTTOM) begin
                        // [RULE8] dual-slope overflow at bottom
                        ovf_event        = 1'b1;
                        state_next.down  = 1'b0;
                        state_next.count = state_reg.count + tcu_pkg::COUNT_ONE;
                    end else begin
                        state_next.count = state_reg.count - tcu_pkg::COUNT_ONE;
                    end
                end
                tcu_pkg::TCU_SEQ_FAST: begin
                    state_next.down = 1'b0;
                    // [RULE8] fast modes overflow at top
                    ovf_event       = at_top;
                    state_next.count = at_top ? tcu_pkg::COUNT_BOTTOM
                                              : state_reg.count + tcu_pkg::COUNT_ONE;
                end
                default: begin
                    state_next.down = 1'b0;
                    // [RULE8] [RULE25] normal and clear-on-top overflow at all ones
                    ovf_event       = (state_reg.count == tcu_pkg::COUNT_MAX);
                    if (seq_kind == tcu_pkg::TCU_SEQ_CTC && at_top) begin
                        state_next.count = tcu_pkg::COUNT_BOTTOM;
                    end else begin
                        state_next.count = state_reg.count + tcu_pkg::COUNT_ONE;
                    end
                end
            endcase
        end

        // [RULE1] [RULE5] [RULE6] low write loads all bits, beats tick
        if (wr_count_lo) begin
            state_next.count = {state_reg.temp, bus_wdata};
        end

        // [RULE3] temp keeps the high byte until rewritten
        if (wr_hi) begin
            state_next.temp = bus_wdata;
        end

        // [RULE13] capture writable only as the top
        if (wr_cap_lo && cap_top_mode) begin
            state_next.capture = {state_reg.temp, bus_wdata};
        end

        // [RULE9] [RULE22] capture overwrites unread data
        if (capture_event) begin
            state_next.capture = state_reg.count;
        end

        // [RULE2] [RULE12] low reads fill temp, high reads return it
        state_next.rdata = tcu_pkg::BYTE_ZERO;
        if (bus_rd && !bus_wr) begin
            case (bus_addr)
                tcu_pkg::LOC_COUNT_LO: state_next.rdata = state_reg.count[7:0];
                tcu_pkg::LOC_CAP_LO:   state_next.rdata = state_reg.capture[7:0];
                default:               state_next.rdata = state_reg.temp;
            endcase
        end
        if (rd_count_lo) begin
            state_next.temp = state_reg.count[15:8];
        end
        if (rd_cap_lo) begin
            state_next.temp = state_reg.capture[15:8];
        end

        // [RULE11] service or written one clears; a same-cycle set still wins
        if (capture_flag_wr1 || capture_irq_ack) begin
            state_next.cap_flag = 1'b0;
        end
        // [RULE10] flag rises with the copy
        if (capture_event) begin
            state_next.cap_flag = 1'b1;
        end
        if (overflow_flag_wr1 || overflow_irq_ack) begin
            state_next.ovf_flag = 1'b0;
        end
        // [RULE8] overflow flag
        if (ovf_event) begin
            state_next.ovf_flag = 1'b1;
        end

        // [RULE10] request gated by enable
        state_next.cap_irq = state_next.cap_flag && capture_irq_en;
        state_next.ovf_irq = state_next.ovf_flag && overflow_irq_en;

        // [RULE7] [RULE25] top and bottom follow the count
        state_next.top    = (state_next.count == top_value);
        state_next.bottom = (state_next.count == tcu_pkg::COUNT_BOTTOM);
    end

    // [RULE27] reset clears everything; bottom is then true
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_reg        <= '0;
            state_reg.bottom <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end
endmodule

// ---- testbench/tcu_cpu_model.sv ----
// processor model: byte writes and reads on the timer core port.
// assumes one clock; requests start after a rising edge.
`timescale 1ns/1ps
module tcu_cpu_model (
    // clock
    input  wire logic       sys_clk,
    // byte port
    output logic            bus_wr,
    output logic            bus_rd,
    output logic      [1:0] bus_addr,
    output logic      [7:0] bus_wdata,
    input  wire logic [7:0] bus_rdata
);
    initial begin
        {bus_wr, bus_rd, bus_addr, bus_wdata} = 12'h000;
    end
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge sys_clk);
        bus_wr <= 1'b0;
        // released lines flip so stale data cannot pass as a write
        bus_addr <= ~a;
        bus_wdata <= ~d;
    endtask
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        #1 d = bus_rdata;
    endtask
    task automatic wr16(input logic [1:0] a, input logic [15:0] x);
        wr(a | 2'h1, x[15:8]);
        wr(a, x[7:0]);
    endtask
    task automatic rd16(input logic [1:0] a, output logic [15:0] x);
        rd(a, x[7:0]);
        rd(a | 2'h1, x[15:8]);
    endtask
endmodule

// ---- testbench/tcu_checker.sv ----
// port relations of the timer core over time.
// bound onto the timer core; one clock domain.
`timescale 1ns/1ps
module tcu_checker (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        reset,
    // byte port
    input wire logic        bus_wr,
    input wire logic        bus_rd,
    input wire logic [1:0]  bus_addr,
    input wire logic [7:0]  bus_wdata,
    input wire logic [7:0]  bus_rdata,
    // configuration and clears
    input wire logic [3:0]  wave_mode_sel,
    input wire logic [2:0]  tick_source_sel,
    input wire logic        capture_irq_en,
    input wire logic        capture_flag_wr1,
    input wire logic        capture_irq_ack,
    // status
    input wire logic [15:0] count_value,
    input wire logic        capture_flag,
    input wire logic        overflow_flag,
    input wire logic        capture_irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
        else $error("read data not idle");
    a_low_write: assert property (bus_wr && bus_addr == 2'h0 |=>
        count_value[7:0] == $past(bus_wdata)) else $error("low write lost");
    a_hi_then_lo: assert property (bus_wr && bus_addr == 2'h1 ##1 !bus_wr && !bus_rd
        ##1 bus_wr && bus_addr == 2'h0 |=> count_value[15:8] == $past(bus_wdata, 3))
        else $error("high byte not from temp");
    a_stop_hold: assert property (tick_source_sel == 3'h0 ##1 !bus_wr |=>
        $stable(count_value)) else $error("stopped counter moved");
    a_wrap_flag: assert property (wave_mode_sel == 4'h0 && !bus_wr
        && count_value == 16'hffff ##1 count_value == 16'h0000 |-> overflow_flag)
        else $error("no overflow at wrap");
    a_irq_gate: assert property (capture_irq == (capture_flag && $past(capture_irq_en)))
        else $error("capture irq not gated");
    a_flag_hold: assert property (capture_flag && !capture_flag_wr1
        && !capture_irq_ack |=> capture_flag) else $error("capture flag lost");
    a_captop_quiet: assert property ((wave_mode_sel == 4'hc) [*8] ##0 !capture_flag
        |=> !capture_flag) else $error("capture in capture-top mode");
endmodule
bind tcu_timer16 tcu_checker i_chk (.*);

// ---- testbench/tcu_timer16_tb.sv ----
// bench for the timer core: port access, counting, capture paths.
// assumes the processor model and the bound checker.
`timescale 1ns/1ps
module tcu_timer16_tb;
    logic        sys_clk, reset, bus_wr, bus_rd;
    logic [1:0]  bus_addr;
    logic [7:0]  bus_wdata, bus_rdata;
    logic [3:0]  wave_mode_sel;
    logic [2:0]  tick_source_sel;
    logic [15:0] compare_value_a, count_value, v;
    logic        filter_enable, edge_rising, comparator_trigger_sel, capture_irq_en;
    logic        overflow_irq_en, capture_flag_wr1, capture_irq_ack, overflow_flag_wr1;
    logic        overflow_irq_ack, capture_pin, capture_port_out, capture_port_dir;
    logic        comparator_out, ext_tick_pin, count_top, count_bottom;
    logic        capture_flag, overflow_flag, capture_irq, overflow_irq;
    int          failures = 0;
    int          n_checks = 0;
    int          cyc = 0;
    int          n0, n1;
    tcu_timer16 i_dut (.*);
    tcu_cpu_model i_cpu (.*);
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures++;
            end_sim;
        end
    end
    task automatic src(input int s, input logic b);
        @(posedge sys_clk);
        case (s)
            0: capture_pin <= b;
            1: comparator_out <= b;
            default: capture_port_out <= b;
        endcase
    endtask
    // cycles until the flag shows, at most 20
    task automatic lat(output int n);
        n = 0;
        while (capture_flag !== 1'b1 && n < 20) begin
            @(posedge sys_clk);
            #1 n++;
        end
    endtask
    // settle first: a source change may capture
    task automatic clr;
        repeat (8) @(posedge sys_clk);
        capture_flag_wr1 <= 1'b1;
        @(posedge sys_clk);
        capture_flag_wr1 <= 1'b0;
    endtask
    initial begin
        {reset, edge_rising} = 2'h3;
        {filter_enable, comparator_trigger_sel, capture_irq_en, overflow_irq_en} = 4'h1;
        {capture_flag_wr1, capture_irq_ack, overflow_flag_wr1, overflow_irq_ack} = 4'h0;
        {capture_pin, capture_port_out, capture_port_dir, comparator_out, ext_tick_pin} = 5'h00;
        wave_mode_sel = 4'h0;
        tick_source_sel = 3'h0;
        compare_value_a = 16'hffff;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        #1 chk("count", 16'h0000, count_value);
        chk("flags", 16'h0001, {capture_flag, overflow_flag, count_bottom});
        i_cpu.rd16(2'h2, v);
        chk("capture", 16'h0000, v);
        i_cpu.wr16(2'h0, 16'h1234);
        #1 chk("count", 16'h1234, count_value);
        i_cpu.rd16(2'h0, v);
        chk("count rd", 16'h1234, v);
        @(posedge sys_clk) wave_mode_sel <= 4'hc;
        i_cpu.wr(2'h3, 8'hab);
        i_cpu.wr(2'h0, 8'h01);
        i_cpu.wr(2'h2, 8'h02);
        i_cpu.rd16(2'h2, v);
        chk("capture", 16'hab02, v);
        chk("count", 16'hab01, count_value);
        @(posedge sys_clk) wave_mode_sel <= 4'h0;
        i_cpu.wr(2'h2, 8'h55);
        i_cpu.rd16(2'h2, v);
        chk("capture", 16'hab02, v);
        i_cpu.wr16(2'h0, 16'hfffd);
        @(posedge sys_clk) tick_source_sel <= 3'h1;
        for (n0 = 0; overflow_flag !== 1'b1 && n0 < 20; n0++) @(posedge sys_clk) #1;
        chk("wrap", 16'h0000, count_value);
        chk("ovf irq", 16'h0005, {overflow_irq, count_top, count_bottom});
        i_cpu.wr16(2'h0, 16'h0500);
        #1 chk("count", 16'h0500, count_value);
        @(posedge sys_clk) tick_source_sel <= 3'h0;
        repeat (3) @(posedge sys_clk);
        v = count_value;
        overflow_flag_wr1 <= 1'b1;
        @(posedge sys_clk) overflow_flag_wr1 <= 1'b0;
        repeat (5) @(posedge sys_clk);
        #1 chk("stopped", v, count_value);
        chk("ovf", 16'h0000, overflow_flag);
        i_cpu.wr16(2'h0, 16'h0100);
        src(0, 1'b1);
        lat(n0);
        chk("latency", 16'h0003, 16'(n0));
        i_cpu.rd16(2'h2, v);
        chk("capture", 16'h0100, v);
        @(posedge sys_clk) edge_rising <= 1'b0;
        filter_enable <= 1'b1;
        clr;
        #1 chk("flag", 16'h0000, capture_flag);
        i_cpu.wr16(2'h0, 16'h0200);
        src(0, 1'b0);
        lat(n1);
        chk("filter", 16'h0004, 16'(n1 - n0));
        i_cpu.rd16(2'h2, v);
        chk("capture", 16'h0200, v);
        clr;
        src(0, 1'b1);
        lat(n1);
        chk("wrong edge", 16'h0000, capture_flag);
        @(posedge sys_clk) {filter_enable, edge_rising} <= 2'h1;
        {comparator_trigger_sel, capture_irq_en} <= 2'h3;
        clr;
        src(1, 1'b1);
        lat(n0);
        chk("cmp", 16'h0003, 16'(n0));
        chk("irq", 16'h0001, capture_irq);
        @(posedge sys_clk) capture_irq_ack <= 1'b1;
        @(posedge sys_clk) capture_irq_ack <= 1'b0;
        #1 chk("ack", 16'h0000, capture_flag);
        @(posedge sys_clk) {comparator_trigger_sel, capture_port_dir} <= 2'h1;
        clr;
        src(2, 1'b1);
        lat(n0);
        chk("port", 16'h0003, 16'(n0));
        @(posedge sys_clk) wave_mode_sel <= 4'hc;
        clr;
        src(2, 1'b0);
        src(2, 1'b1);
        lat(n0);
        chk("top mode", 16'h0000, capture_flag);
        end_sim;
    end
endmodule
